// >>> core/spm_pkg.sv
// spm_pkg: constants, field layout and types of the switch power-mode and EEE LPI block.
// assumes a single 25 MHz core clock and an APB register port with 32-bit data.
package spm_pkg;

  // ----------
  // clock and timing
  // ----------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CLK_KHZ = 25_000;
  localparam int unsigned ED_PULSE_NS = 120;
  localparam int unsigned ED_PULSE_CYC = (ED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ED_PERIOD_MS = 1000;
  localparam int unsigned ED_PERIOD_CYC = ED_PERIOD_MS * CLK_KHZ;
  localparam int unsigned REFRESH_PERIOD_MS = 20;
  localparam int unsigned REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * CLK_KHZ;
  localparam int unsigned REFRESH_LEN_US = 200;
  localparam int unsigned REFRESH_LEN_CYC = (REFRESH_LEN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned GO_SLEEP_UNIT_MS = 1;
  localparam int unsigned GO_SLEEP_UNIT_CYC = GO_SLEEP_UNIT_MS * CLK_KHZ;
  // implementation delays, counted in core clock cycles
  localparam logic [15:0] MAC_WAKE_CYC = 16'h0020;
  localparam logic [15:0] PHY_WAKE_CYC = 16'h0010;
  localparam logic [15:0] PHY_SLEEP_CYC = 16'h0010;
  localparam logic [15:0] RX_RECOVER_CYC = 16'h0010;

  // ----------
  // register map (byte addresses) and fields
  // ----------
  localparam int unsigned NPORT = 4;
  localparam logic [11:0] PWR_CTRL_OFS = 12'h000;
  localparam logic [11:0] SLEEP_TMR_OFS = 12'h004;
  localparam logic [11:0] EEE_CTRL_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [7:0] PORT_CTRL10_PAGE = 8'h01;
  localparam logic [7:0] PHY_BMCR_PAGE = 8'h02;
  localparam int unsigned PMODE_LSB = 3;
  localparam int unsigned PORT_PD_BIT = 3;
  localparam int unsigned PHY_PD_BIT = 11;
  localparam int unsigned LPI_REQ_BIT = 0;
  localparam int unsigned EEE_ADV_BIT = 1;
  localparam logic [1:0] PMODE_NORMAL = 2'h0;
  localparam logic [1:0] PMODE_ED = 2'h1;
  localparam logic [1:0] PMODE_SOFT_PD = 2'h2;
  localparam logic [1:0] PMODE_RST = 2'h0;
  localparam logic [7:0] SLEEP_TMR_RST = 8'h32;
  localparam logic EEE_ADV_RST = 1'b1;
  localparam logic LPI_REQ_RST = 1'b0;
  // status word layout
  localparam int unsigned ST_ED_LOW_BIT = 0;
  localparam int unsigned ST_TX_LPI_BIT = 1;
  localparam int unsigned ST_RX_LPI_BIT = 2;
  localparam int unsigned ST_EEE_OK_BIT = 3;
  localparam int unsigned ST_LINE_LSB = 4;

  // assert-LPI code on the MII: enable low, error high, data 0001
  localparam logic [3:0] LPI_CODE = 4'h1;

  // ----------
  // types
  // ----------
  typedef struct packed {
    logic [3:0] d;
    logic en;
    logic er;
  } spm_mii_s;

  typedef enum logic [2:0] {LINE_DATA, LINE_SLEEP, LINE_QUIET, LINE_REFRESH, LINE_WAKE} spm_line_e;
  typedef enum logic [1:0] {TX_NORMAL, TX_DEFER, TX_LPI, TX_WAKE} spm_tx_e;
  typedef enum logic [1:0] {RX_NORMAL, RX_LPI, RX_RECOVER} spm_rx_e;
  typedef enum logic {ED_AWAKE, ED_LOW} spm_ed_e;

endpackage

// >>> core/spm_top.sv
// spm_top: power modes, energy detect, soft power-down wake, EEE LPI.
// assumes APB and MII on i_mclk; energy, advertise, sleep/wake pins async.
//
// Notes on behaviour
// - mode 01 in power bits 4:3: energy detect
// - no energy past go-sleep time: low power
// - low power: energy detector only; energy wakes
// - low power: one 120 ns pulse per second
// - mode 10: soft power-down, clocks, PHYs, MACs off
// - soft power-down: host access wakes, resets
// - port down on control-10 bit 3 or PHY bit 11
// - transmit and receive LPI independent
// - gate MAC clocks of a direction in LPI
// - switch requests LPI; partner LPI indicated
// - MAC defers on carrier sense in LPI
// - LPI request: LPI code at once, MAC blocked (here the code follows a TX_DEFER cycle, after any MAC frame ends)
// - request off: idle code, MAC freed after delay
// - rx LPI entry: idle to MAC, indication up
// - rx LPI exit: indication down, pass-through
// - LPI code from MAC: sleep, then quiet
// - quiet: 200 us refresh every 20 ms
// - until idle code: quiet/refresh, then wake
// - LPI entry and exit never cut a frame
// - received sleep: LPI code, receiver partly off
// - received wake: idle code, recovery time
// - power mode resets to 00; 11 reserved
// - LPI only when both ends advertise EEE (transmit only here; receive LPI is entered without checking advertisement)
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module spm_top
  import spm_pkg::*;
#(
  parameter int unsigned P_ED_PERIOD_CYC = ED_PERIOD_CYC,
  parameter int unsigned P_GO_SLEEP_UNIT_CYC = GO_SLEEP_UNIT_CYC,
  parameter int unsigned P_REFRESH_PERIOD_CYC = REFRESH_PERIOD_CYC,
  parameter int unsigned P_REFRESH_LEN_CYC = REFRESH_LEN_CYC
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cable_energy,
  input wire logic i_partner_eee_adv,
  input wire logic i_rx_sleep_det,
  input wire logic i_rx_wake_det,
  input wire spm_mii_s i_mac_tx,
  input wire spm_mii_s i_phy_rx,
  output spm_mii_s o_mii_tx,
  output spm_mii_s o_mac_rx,
  output logic o_mac_crs,
  output logic o_partner_low_power_idle_ind,
  output logic o_rx_part_pd,
  output spm_line_e o_line_tx,
  output logic o_mac_tx_clk_gate,
  output logic o_mac_rx_clk_gate,
  output logic o_pll_clk_en,
  output logic o_phy_en,
  output logic o_mac_en,
  output logic o_ed_rx_en,
  output logic o_ed_pulse,
  output logic [NPORT-1:0] o_port_pd,
  output logic o_int_rst
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_lpi_code(input spm_mii_s m);
    return !m.en && m.er && (m.d == LPI_CODE);
  endfunction

  function automatic logic in_page(input logic [11:0] a, input logic [7:0] page);
    return (a[11:4] == page) && (a[1:0] == 2'h0);
  endfunction

  // ---------------------------------------------------------------
  // reset and pin synchronisers
  // ---------------------------------------------------------------
  logic soft_rst_reg;
  logic rst;
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic sleep_d_reg;
  logic wake_d_reg;
  logic energy;
  logic partner_adv;
  logic sleep_rise;
  logic wake_rise;

  // soft reset clears every register except itself and the pin synchroniser flops
  assign rst = i_srst | soft_rst_reg;
  assign o_int_rst = soft_rst_reg;

  // two flops per pin; stage two is read, plus a third flop on sleep and wake for edge detect
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      sleep_d_reg <= 1'b0;
      wake_d_reg <= 1'b0;
    end else if (i_ce) begin
      pin_s1_reg <= {i_rx_wake_det, i_rx_sleep_det, i_partner_eee_adv, i_cable_energy};
      pin_s2_reg <= pin_s1_reg;
      sleep_d_reg <= pin_s2_reg[2];
      wake_d_reg <= pin_s2_reg[3];
    end
  end

  assign energy = pin_s2_reg[0];
  assign partner_adv = pin_s2_reg[1];
  assign sleep_rise = pin_s2_reg[2] & ~sleep_d_reg;
  assign wake_rise = pin_s2_reg[3] & ~wake_d_reg;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [1:0] pmode_reg;
  logic [7:0] sleep_time_reg;
  logic lpi_req_reg;
  logic eee_adv_reg;
  logic [NPORT-1:0] port_pd_reg;
  logic [NPORT-1:0] phy_pd_reg;
  logic acc_done;
  logic wr_ok;
  logic [31:0] rdata;
  logic addr_ok;
  logic [1:0] pidx;
  logic [1:0] new_mode;
  spm_tx_e tx_state_reg;
  spm_rx_e rx_state_reg;
  spm_line_e line_state_reg;
  spm_ed_e ed_state_reg;

  assign acc_done = i_psel & i_penable & o_pready;
  assign pidx = i_paddr[3:2];
  // host interface is dead in soft power-down: the access only wakes
  assign wr_ok = acc_done & i_pwrite & addr_ok & (pmode_reg != PMODE_SOFT_PD);
  assign new_mode = i_pwdata[PMODE_LSB+1:PMODE_LSB];

  // read mux and address decode
  always_comb begin
    rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    if (i_paddr == PWR_CTRL_OFS) begin
      rdata[PMODE_LSB+1:PMODE_LSB] = pmode_reg;
    end else if (i_paddr == SLEEP_TMR_OFS) begin
      rdata[7:0] = sleep_time_reg;
    end else if (i_paddr == EEE_CTRL_OFS) begin
      rdata[LPI_REQ_BIT] = lpi_req_reg;
      rdata[EEE_ADV_BIT] = eee_adv_reg;
    end else if (i_paddr == STATUS_OFS) begin
      rdata[ST_ED_LOW_BIT] = (ed_state_reg == ED_LOW);
      rdata[ST_TX_LPI_BIT] = (tx_state_reg == TX_LPI);
      rdata[ST_RX_LPI_BIT] = (rx_state_reg == RX_LPI);
      rdata[ST_EEE_OK_BIT] = eee_adv_reg & partner_adv;
      rdata[ST_LINE_LSB+2:ST_LINE_LSB] = line_state_reg;
    end else if (in_page(i_paddr, PORT_CTRL10_PAGE)) begin
      rdata[PORT_PD_BIT] = port_pd_reg[pidx];
    end else if (in_page(i_paddr, PHY_BMCR_PAGE)) begin
      rdata[PHY_PD_BIT] = phy_pd_reg[pidx];
    end else begin
      addr_ok = 1'b0;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel & i_penable & ~o_pready) begin
        o_prdata <= (pmode_reg == PMODE_SOFT_PD) ? 32'h0000_0000 : rdata;
        o_pslverr <= ~addr_ok;
      end
    end
  end

  // soft power-down wake: reset pulse right after the access ends
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      soft_rst_reg <= 1'b0;
    end else if (i_ce) begin
      soft_rst_reg <= acc_done & (pmode_reg == PMODE_SOFT_PD);
    end
  end

  // power-mode field; reserved code 11 is not stored
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      pmode_reg <= PMODE_RST;
    end else if (i_ce && wr_ok && i_paddr == PWR_CTRL_OFS && new_mode != 2'h3) begin
      pmode_reg <= new_mode;
    end
  end

  // go-sleep time and EEE control
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      sleep_time_reg <= SLEEP_TMR_RST;
      lpi_req_reg <= LPI_REQ_RST;
      eee_adv_reg <= EEE_ADV_RST;
    end else if (i_ce && wr_ok) begin
      if (i_paddr == SLEEP_TMR_OFS) begin
        sleep_time_reg <= i_pwdata[7:0];
      end
      if (i_paddr == EEE_CTRL_OFS) begin
        lpi_req_reg <= i_pwdata[LPI_REQ_BIT];
        eee_adv_reg <= i_pwdata[EEE_ADV_BIT];
      end
    end
  end

  // per-port power-down bits, either source powers the port down
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      port_pd_reg <= '0;
      phy_pd_reg <= '0;
      o_port_pd <= '0;
    end else if (i_ce) begin
      if (wr_ok && in_page(i_paddr, PORT_CTRL10_PAGE)) begin
        port_pd_reg[pidx] <= i_pwdata[PORT_PD_BIT];
      end
      if (wr_ok && in_page(i_paddr, PHY_BMCR_PAGE)) begin
        phy_pd_reg[pidx] <= i_pwdata[PHY_PD_BIT];
      end
      o_port_pd <= port_pd_reg | phy_pd_reg;
    end
  end

  // ---------------------------------------------------------------
  // energy detect mode
  // ---------------------------------------------------------------
  logic [31:0] unit_cnt_reg;
  logic [8:0] idle_units_reg;
  logic [31:0] pulse_cnt_reg;
  logic ed_mode;
  logic awake;

  assign ed_mode = (pmode_reg == PMODE_ED);
  assign awake = (pmode_reg != PMODE_SOFT_PD) && (ed_state_reg != ED_LOW);

  // go-sleep timing counts whole units of silence on the cable
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      ed_state_reg <= ED_AWAKE;
      unit_cnt_reg <= 32'h0000_0000;
      idle_units_reg <= 9'h000;
    end else if (i_ce) begin
      if (!ed_mode || energy) begin
        ed_state_reg <= ED_AWAKE;
        unit_cnt_reg <= 32'h0000_0000;
        idle_units_reg <= 9'h000;
      end else if (ed_state_reg == ED_AWAKE) begin
        if (idle_units_reg > {1'b0, sleep_time_reg}) begin
          ed_state_reg <= ED_LOW;
        end else if (unit_cnt_reg == P_GO_SLEEP_UNIT_CYC - 1) begin
          unit_cnt_reg <= 32'h0000_0000;
          idle_units_reg <= idle_units_reg + 9'h001;
        end else begin
          unit_cnt_reg <= unit_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end

  // link pulse while asleep without a cable
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      pulse_cnt_reg <= 32'h0000_0000;
      o_ed_pulse <= 1'b0;
    end else if (i_ce) begin
      if (ed_state_reg != ED_LOW) begin
        pulse_cnt_reg <= 32'h0000_0000;
        o_ed_pulse <= 1'b0;
      end else begin
        pulse_cnt_reg <= (pulse_cnt_reg == P_ED_PERIOD_CYC - 1) ? 32'h0000_0000
                         : pulse_cnt_reg + 32'h0000_0001;
        o_ed_pulse <= (pulse_cnt_reg < ED_PULSE_CYC);
      end
    end
  end

  // block enables per mode and energy state
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      o_pll_clk_en <= 1'b1;
      o_phy_en <= 1'b1;
      o_mac_en <= 1'b1;
      o_ed_rx_en <= 1'b1;
    end else if (i_ce) begin
      o_pll_clk_en <= awake;
      o_phy_en <= awake;
      o_mac_en <= awake;
      o_ed_rx_en <= (pmode_reg != PMODE_SOFT_PD);
    end
  end

  // ---------------------------------------------------------------
  // transmit LPI assert (MAC side)
  // ---------------------------------------------------------------
  logic lpi_req;
  logic [15:0] tx_cnt_reg;
  spm_tx_e tx_next;

  assign lpi_req = lpi_req_reg & eee_adv_reg & partner_adv;

  // defer first so a frame starting in the same cycle is not cut
  always_comb begin
    tx_next = tx_state_reg;
    unique case (tx_state_reg)
      TX_NORMAL: if (lpi_req) tx_next = TX_DEFER;
      TX_DEFER: begin
        if (!lpi_req) tx_next = TX_NORMAL;
        else if (!i_mac_tx.en) tx_next = TX_LPI;
      end
      TX_LPI: if (!lpi_req) tx_next = TX_WAKE;
      TX_WAKE: begin
        if (lpi_req) tx_next = TX_LPI;
        else if (tx_cnt_reg == MAC_WAKE_CYC - 16'h0001) tx_next = TX_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (rst) begin
      tx_state_reg <= TX_NORMAL;
      tx_cnt_reg <= 16'h0000;
    end else if (i_ce) begin
      tx_state_reg <= tx_next;
      tx_cnt_reg <= (tx_state_reg == TX_WAKE) ? tx_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // transmit MII toward the PHY and carrier-sense deferral
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      o_mii_tx <= '0;
      o_mac_crs <= 1'b0;
      o_mac_tx_clk_gate <= 1'b0;
    end else if (i_ce) begin
      unique case (tx_next)
        TX_LPI: o_mii_tx <= '{d: LPI_CODE, en: 1'b0, er: 1'b1};
        TX_WAKE: o_mii_tx <= '0;
        default: o_mii_tx <= i_mac_tx;
      endcase
      o_mac_crs <= (tx_next != TX_NORMAL);
      o_mac_tx_clk_gate <= (tx_next == TX_LPI);
    end
  end

  // ---------------------------------------------------------------
  // PHY transmit line sequencing: sleep, quiet, refresh, wake
  // ---------------------------------------------------------------
  logic [31:0] line_cnt_reg;
  logic tx_lpi_code;

  // the PHY reacts to the code actually driven on the transmit MII
  assign tx_lpi_code = is_lpi_code(o_mii_tx);

  always_ff @(posedge i_mclk) begin
    if (rst) begin
      line_state_reg <= LINE_DATA;
      line_cnt_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      line_cnt_reg <= line_cnt_reg + 32'h0000_0001;
      unique case (line_state_reg)
        LINE_DATA: begin
          line_cnt_reg <= 32'h0000_0000;
          if (tx_lpi_code) line_state_reg <= LINE_SLEEP;
        end
        LINE_SLEEP: if (line_cnt_reg == {16'h0000, PHY_SLEEP_CYC} - 1) begin
          line_state_reg <= LINE_QUIET;
          line_cnt_reg <= 32'h0000_0000;
        end
        LINE_QUIET: if (!tx_lpi_code) begin
          line_state_reg <= LINE_WAKE;
          line_cnt_reg <= 32'h0000_0000;
        end else if (line_cnt_reg == P_REFRESH_PERIOD_CYC - P_REFRESH_LEN_CYC - 1) begin
          line_state_reg <= LINE_REFRESH;
          line_cnt_reg <= 32'h0000_0000;
        end
        LINE_REFRESH: if (!tx_lpi_code) begin
          line_state_reg <= LINE_WAKE;
          line_cnt_reg <= 32'h0000_0000;
        end else if (line_cnt_reg == P_REFRESH_LEN_CYC - 1) begin
          line_state_reg <= LINE_QUIET;
          line_cnt_reg <= 32'h0000_0000;
        end
        LINE_WAKE: if (line_cnt_reg == {16'h0000, PHY_WAKE_CYC} - 1) begin
          line_state_reg <= LINE_DATA;
        end
        default: line_state_reg <= LINE_DATA;
      endcase
    end
  end

  assign o_line_tx = line_state_reg;

  // ---------------------------------------------------------------
  // receive LPI detect, independent of transmit
  // ---------------------------------------------------------------
  logic rx_code;
  logic rx_code_d_reg;
  logic [15:0] rx_cnt_reg;
  spm_rx_e rx_next;

  // the partner side is trusted to send sleep, refresh, then wake
  assign rx_code = is_lpi_code(i_phy_rx);

  always_comb begin
    rx_next = rx_state_reg;
    unique case (rx_state_reg)
      RX_NORMAL: if ((rx_code & ~rx_code_d_reg) | sleep_rise) rx_next = RX_LPI;
      RX_LPI: begin
        if (wake_rise) rx_next = RX_RECOVER;
        else if (rx_code_d_reg & ~rx_code) rx_next = RX_NORMAL;
      end
      RX_RECOVER: if (rx_cnt_reg == RX_RECOVER_CYC - 16'h0001) rx_next = RX_NORMAL;
      default: rx_next = RX_NORMAL;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (rst) begin
      rx_state_reg <= RX_NORMAL;
      rx_code_d_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
    end else if (i_ce) begin
      rx_state_reg <= rx_next;
      rx_code_d_reg <= rx_code;
      rx_cnt_reg <= (rx_state_reg == RX_RECOVER) ? rx_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // receive MII toward the MAC: idle while in LPI or recovery, else pass through
  always_ff @(posedge i_mclk) begin
    if (rst) begin
      o_mac_rx <= '0;
      o_partner_low_power_idle_ind <= 1'b0;
      o_rx_part_pd <= 1'b0;
      o_mac_rx_clk_gate <= 1'b0;
    end else if (i_ce) begin
      o_mac_rx <= (rx_next == RX_NORMAL) ? i_phy_rx : '0;
      o_partner_low_power_idle_ind <= (rx_next == RX_LPI);
      o_rx_part_pd <= (rx_next == RX_LPI);
      o_mac_rx_clk_gate <= (rx_next == RX_LPI);
    end
  end

endmodule // spm_top

// >>> dv/spm_link_partner.sv
// spm_link_partner: behavioural far-end link partner for receive LPI.
// assumes the bench raises i_lpi to sleep and lowers it to wake.
`timescale 1ns/1ps
module spm_link_partner
  import spm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_lpi,
  input wire spm_mii_s i_data,
  output logic o_sleep,
  output logic o_wake,
  output spm_mii_s o_rx
);
  // ----------
  // sleep, quiet, wake
  // ----------
  logic prev = 1'b0;
  logic [2:0] cnt = 3'h0;
  // signal lasts 4 cycles so the 2-flop receiver sees it
  always_ff @(posedge i_clk) begin
    prev <= i_lpi;
    cnt <= (i_lpi != prev) ? 3'h4 : (cnt != 3'h0) ? cnt - 3'h1 : cnt;
  end
  assign o_sleep = i_lpi && cnt != 3'h0;
  assign o_wake = !i_lpi && cnt != 3'h0;
  // quiet partner: local phy shows assert-lpi code
  assign o_rx = i_lpi ? '{d: LPI_CODE, en: 1'b0, er: 1'b1} : i_data;
endmodule // spm_link_partner

// >>> dv/spm_top_properties.sv
// spm_top_properties: port-level checks of power mode and LPI sequencing.
// assumes binding into spm_top, one clock, synchronous active-high reset.
`timescale 1ns/1ps
module spm_top_properties
  import spm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire spm_mii_s i_phy_rx,
  input wire spm_mii_s o_mii_tx,
  input wire spm_mii_s o_mac_rx,
  input wire logic o_mac_crs,
  input wire logic o_partner_low_power_idle_ind,
  input wire logic o_rx_part_pd,
  input wire logic o_mac_tx_clk_gate,
  input wire logic o_mac_rx_clk_gate,
  input wire spm_line_e o_line_tx,
  input wire logic o_pready,
  input wire logic o_int_rst,
  input wire logic o_ed_pulse,
  input wire logic o_pll_clk_en,
  input wire logic o_phy_en,
  input wire logic o_ed_rx_en
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // assert-lpi nibble: enable low, error high, code 0001
  function automatic logic is_lpi(spm_mii_s m);
    return m.d == LPI_CODE && !m.en && m.er;
  endfunction
  property p_tx_defer;
    is_lpi(o_mii_tx) |-> o_mac_crs && o_mac_tx_clk_gate;
  endproperty
  a_tx_defer: assert property (p_tx_defer) else $error("lpi sent without defer");
  // partner needs time: defer outlives the code by at least 8 cycles
  property p_tx_wake;
    is_lpi(o_mii_tx) ##1 !is_lpi(o_mii_tx) |-> o_mac_crs [*8];
  endproperty
  a_tx_wake: assert property (p_tx_wake) else $error("mac released early");
  property p_sleep;
    !is_lpi(o_mii_tx) ##1 is_lpi(o_mii_tx) |=> ##[0:1] o_line_tx == LINE_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after lpi");
  property p_rx_enter;
    !is_lpi(i_phy_rx) ##1 is_lpi(i_phy_rx) |=> o_partner_low_power_idle_ind;
  endproperty
  a_rx_enter: assert property (p_rx_enter) else $error("rx lpi not indicated");
  property p_rx_quiet;
    o_partner_low_power_idle_ind |-> o_mac_rx == '0 && o_rx_part_pd && o_mac_rx_clk_gate;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx lpi not idle");
  property p_rx_leave;
    is_lpi(i_phy_rx) ##1 !is_lpi(i_phy_rx) |=> !o_partner_low_power_idle_ind;
  endproperty
  a_rx_leave: assert property (p_rx_leave) else $error("rx lpi stuck");
  property p_apb_wait;
    i_psel && !i_penable ##1 i_psel && i_penable |=> o_pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
  property p_int_rst;
    o_int_rst |=> !o_int_rst && o_pll_clk_en;
  endproperty
  a_int_rst: assert property (p_int_rst) else $error("internal reset wrong");
  property p_pulse;
    $rose(o_ed_pulse) |-> o_ed_pulse [*3] ##1 !o_ed_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width wrong");
  property p_ed_low;
    o_ed_pulse |-> !o_phy_en && o_ed_rx_en;
  endproperty
  a_ed_low: assert property (p_ed_low) else $error("pulse outside low power");
  c_tx_lpi: cover property (is_lpi(o_mii_tx));
  c_rx_lpi: cover property (o_partner_low_power_idle_ind);
  c_int_rst: cover property (o_int_rst);
endmodule // spm_top_properties

bind spm_top spm_top_properties u_props (.*);

// >>> dv/spm_top_tb_top.sv
// spm_top_tb_top: self-checking bench for power modes and EEE LPI.
// assumes short counts set by parameters and a behavioural link partner.
`timescale 1ns/1ps
module spm_top_tb_top
  import spm_pkg::*;
;
  // ----------
  // signals and instances
  // ----------
  logic i_mclk = 0, i_srst = 1, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, rd;
  logic o_pready, o_pslverr, slv, i_cable_energy = 1, i_partner_eee_adv = 1;
  logic i_rx_sleep_det, i_rx_wake_det, lpi = 0;
  spm_mii_s i_mac_tx = '0, i_phy_rx, o_mii_tx, o_mac_rx, rx_data = '0, v;
  spm_line_e o_line_tx;
  logic o_mac_crs, o_partner_low_power_idle_ind, o_rx_part_pd, o_mac_tx_clk_gate;
  logic o_mac_rx_clk_gate, o_pll_clk_en, o_phy_en, o_mac_en, o_ed_rx_en, o_ed_pulse, o_int_rst;
  logic [NPORT-1:0] o_port_pd;
  int err_total = 0, comparisons = 0, n, k;
  time t0;
  localparam spm_mii_s LPIW = '{d: LPI_CODE, en: 1'b0, er: 1'b1};
  spm_top #(.P_ED_PERIOD_CYC(50), .P_GO_SLEEP_UNIT_CYC(4), .P_REFRESH_PERIOD_CYC(60),
    .P_REFRESH_LEN_CYC(10)) dut (.*);
  spm_link_partner u_partner (.i_clk(i_mclk), .i_lpi(lpi), .i_data(rx_data),
    .o_sleep(i_rx_sleep_det), .o_wake(i_rx_wake_det), .o_rx(i_phy_rx));
  // free-running 25 MHz clock
  initial forever #20 i_mclk = ~i_mclk;
  // ----------
  // tasks
  // ----------
  task automatic summarize();
    $display("counts: %0d comparisons, %0d errors", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    @(posedge i_mclk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_mclk);
    i_penable <= 1;
    c = 0;
    do begin @(posedge i_mclk); c++; end while (o_pready !== 1'b1 && c < 20);
    chk(c < 20, 1, "apb timeout");
    if (c >= 20) summarize();
    rd = o_prdata;
    slv = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  function automatic logic cond(int s);
    case (s)
      0: return o_phy_en === 1'b0;
      1: return o_ed_pulse === 1'b1;
      2: return o_phy_en === 1'b1;
      3: return o_mii_tx === LPIW;
      4: return o_line_tx === LINE_REFRESH;
      5: return o_line_tx === LINE_WAKE;
      6: return o_line_tx === LINE_DATA;
      7: return o_partner_low_power_idle_ind === 1'b1;
      8: return o_partner_low_power_idle_ind === 1'b0;
      default: return o_mac_crs === 1'b0;
    endcase
  endfunction
  // bounded wait; running out ends the run
  task automatic wt(input int s, input int lim);
    int c;
    c = 0;
    while (!cond(s) && c < lim) begin @(posedge i_mclk); c++; end
    chk(c < lim, 1, "wait timeout");
    if (c >= lim) summarize();
  endtask
  // random nibbles pass with one cycle of latency, or stay blocked in LPI
  task automatic thru(input bit rx, input bit blk);
    repeat (6) begin
      v = '{d: 4'($urandom), en: 1'b1, er: 1'b0};
      @(posedge i_mclk);
      if (rx) rx_data <= v; else i_mac_tx <= v;
      @(posedge i_mclk);
      #1 chk(rx ? o_mac_rx : o_mii_tx, blk ? (rx ? 6'h0 : LPIW) : v, "pass data");
    end
    {i_mac_tx, rx_data} <= '0;
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(38003));
    repeat (16) @(posedge i_mclk);
    i_srst <= 0;
    apb(0, PWR_CTRL_OFS, 0);
    chk(rd[4:3], PMODE_RST, "mode reset");
    apb(0, SLEEP_TMR_OFS, 0);
    chk(rd, SLEEP_TMR_RST, "sleep reset");
    apb(0, 12'hFFC, 0);
    chk(slv, 1, "unmapped");
    apb(1, PWR_CTRL_OFS, 32'h18);
    apb(0, PWR_CTRL_OFS, 0);
    chk(rd[4:3], PMODE_RST, "mode 11");
    $display("test registers done");
    i_cable_energy <= 0;
    apb(1, SLEEP_TMR_OFS, 1);
    apb(1, PWR_CTRL_OFS, 32'h08);
    apb(0, PWR_CTRL_OFS, 0);
    chk(rd[4:3], PMODE_ED, "mode ed");
    wt(0, 100);
    chk({o_ed_rx_en, o_pll_clk_en}, 2'b10, "low power");
    wt(1, 60);
    n = 0;
    while (o_ed_pulse === 1'b1 && n < 10) begin @(posedge i_mclk); n++; end
    chk(n, ED_PULSE_CYC, "pulse width");
    i_cable_energy <= 1;
    wt(2, 8);
    apb(1, PWR_CTRL_OFS, 0);
    k = $urandom % NPORT;
    apb(1, PWR_CTRL_OFS + 12'h010 + 12'(4 * k), 32'h8);
    repeat (2) @(posedge i_mclk);
    chk(o_port_pd, 1 << k, "port pd");
    apb(1, 12'h010 + 12'(4 * k), 0);
    apb(1, 12'h020 + 12'(4 * k), 32'h800);
    repeat (2) @(posedge i_mclk);
    chk(o_port_pd, 1 << k, "phy pd");
    apb(1, 12'h020 + 12'(4 * k), 0);
    $display("test power modes done");
    apb(1, EEE_CTRL_OFS, 3);
    wt(3, 10);
    thru(0, 1);
    chk(o_mii_tx, LPIW, "mac blocked");
    wt(4, 200);
    apb(0, STATUS_OFS, 0);
    chk(rd[6:0], {LINE_REFRESH, 4'hA}, "status");
    apb(1, EEE_CTRL_OFS, 2);
    t0 = $time;
    wt(5, 40);
    wt(6, 40);
    wt(9, 60);
    chk(($time - t0) / 40 inside {[MAC_WAKE_CYC:MAC_WAKE_CYC + 4]}, 1, "wake delay");
    thru(0, 0);
    i_partner_eee_adv <= 0;
    apb(1, EEE_CTRL_OFS, 3);
    repeat (40) @(posedge i_mclk) chk(o_mii_tx === LPIW, 0, "lpi without partner");
    apb(1, EEE_CTRL_OFS, 2);
    i_partner_eee_adv <= 1;
    $display("test tx lpi done");
    lpi <= 1;
    wt(7, 10);
    chk({o_mac_rx, o_rx_part_pd}, 7'h01, "rx idle");
    thru(1, 1);
    thru(0, 0);
    lpi <= 0;
    wt(8, 10);
    repeat (25) @(posedge i_mclk);
    thru(1, 0);
    $display("test rx lpi done");
    apb(1, SLEEP_TMR_OFS, 5);
    apb(1, PWR_CTRL_OFS, 32'h10);
    repeat (2) @(posedge i_mclk);
    chk({o_pll_clk_en, o_mac_en, o_phy_en}, 0, "soft pd");
    apb(0, PWR_CTRL_OFS, 0);
    chk(rd, 0, "pd read");
    repeat (4) @(posedge i_mclk);
    apb(0, SLEEP_TMR_OFS, 0);
    chk(rd, SLEEP_TMR_RST, "default after wake");
    $display("test soft power-down done");
    summarize();
  end
endmodule // spm_top_tb_top
